// File: logic/capture_compare_unit.sv
/*
  Sixteen-channel capture/compare unit with two reloadable 16-bit time bases and an APB slave.
  Assumes one clock clk_sys, a synchronous active-high reset, channel pins and the external
  count pin from outside the clock domain, and upstream_ovf as a one-cycle pulse on clk_sys.
*/
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "capcom_cfg.svh"

//Contract
// - Sixteen capture/compare channels exist.
// - Resolution is one clock, or eight clocks in staggered mode.
// - Two independent 16-bit timers, each with its own reload register.
// - Each timer ticks from a prescaled clock or from upstream timer overflows.
// - The first timer can instead count external input events.
// - Each channel picks either timer and capture or compare function.
// - Each channel owns one pin: capture input or compare output.
// - Compare mode 0 interrupts on every match, pin untouched.
// - Compare mode 1 toggles the pin on every match.
// - Compare mode 2 interrupts only on the first match per period.
// - Compare mode 3 sets pin on match, clears on overflow, once per period.
// - Double-register mode lets two channels toggle one shared pin.
// - Single-event option allows one edge or pulse, then the channel stops; the code sets done only on a compare match, so captures go on.
// - A qualifying pin edge copies the assigned timer into the channel.
// - Every capture raises that channel's interrupt request.
// - Capture edge selects rising, falling or both edges per channel.
// - Compare channels check their timer on each update and act on match.
module capture_compare_unit #(
  parameter int CHANNELS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] pin_in,
  output logic [CHANNELS-1:0] pin_out,
  output logic [CHANNELS-1:0] pin_oe_n,
  input wire logic ext_count,
  input wire logic upstream_ovf,
  output logic irq
);

  localparam int PAIRS = CHANNELS / 2;

  logic [15:0] timer [2];
  logic [15:0] reload [2];
  logic [1:0] run;
  logic [2:0] psc [2];
  capcom_pkg::tb_src_t src [2];
  logic stagger;
  logic [CHANNELS+1:0] status;
  logic [CHANNELS+1:0] mask;
  logic [PAIRS-1:0] double_en;
  logic [15:0] value [CHANNELS];
  capcom_pkg::ch_mode_t mode [CHANNELS];
  logic [CHANNELS-1:0] tsel;
  logic [CHANNELS-1:0] single;
  logic [CHANNELS-1:0] done;
  logic [CHANNELS-1:0] fired;
  logic [CHANNELS-1:0] pin_s1;
  logic [CHANNELS-1:0] pin_s2;
  logic [CHANNELS-1:0] pin_s3;
  logic [2:0] ext_sync;
  logic [7:0] psc_cnt;
  logic [2:0] slot;
  logic [1:0] upd;
  logic [1:0] ovf_d;
  logic [1:0] tick;
  logic [1:0] ovf;
  logic [CHANNELS-1:0] capture;
  logic [CHANNELS-1:0] act;
  logic [CHANNELS-1:0] partner_act;
  logic [CHANNELS+1:0] events;
  logic [CHANNELS+1:0] reported;
  logic status_rd;
  logic [CHANNELS-1:0] next_pin;
  logic [CHANNELS-1:0] next_oe_n;
  logic [31:0] rd_word;
  logic rd_hit;
  logic access;
  logic wr_en;
  logic rd_done;
  logic [3:0] ch_idx;
  logic value_sel;
  logic mode_sel;

  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign rd_done = access & pready & ~pwrite;
  assign ch_idx = paddr[5:2];
  assign value_sel = paddr[7:6] == 2'b01;
  assign mode_sel = paddr[7:6] == 2'b10;
  // Channel k+PAIRS is the second register of pair k; rotating keeps every index in range.
  assign partner_act = {act[PAIRS-1:0], act[CHANNELS-1:PAIRS]};
  assign events = {ovf_d, capture | act};
  assign status_rd = rd_done && paddr == `CC_OFF_STATUS;
  // Only what the completing read reported is cleared; prdata holds exactly that word.
  assign reported = status_rd ? prdata[CHANNELS+1:0] : '0;

  // Pins and the count input are asynchronous; nothing but the next stage reads stage one.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      ext_sync <= 3'h0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      ext_sync <= {ext_sync[1:0], ext_count};
    end
  end

  // Both counters run free, so the first prescaled tick after a start may come early.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      psc_cnt <= 8'h00;
      slot <= 3'h0;
    end else begin
      psc_cnt <= psc_cnt + 8'h01;
      slot <= (slot == `CC_STAGGER_SLOTS) ? 3'h0 : slot + 3'h1;
    end
  end

  // Tick selection; staggered mode lets a timer move only in slot zero of eight.
  always_comb begin
    logic [7:0] pmask;
    logic raw;
    pmask = 8'h00;
    raw = 1'b0;
    for (int t = 0; t < 2; t++) begin
      pmask = 8'((9'h001 << psc[t]) - 9'h001);
      case (src[t])
        capcom_pkg::SRC_PRESCALED: raw = (psc_cnt & pmask) == pmask;
        capcom_pkg::SRC_UPSTREAM: raw = upstream_ovf;
        capcom_pkg::SRC_EXTERNAL: raw = (t == 0) && ext_sync[1] && !ext_sync[2];
        default: raw = 1'b0;
      endcase
      tick[t] = run[t] & raw & (~stagger | (slot == 3'h0));
      ovf[t] = tick[t] & (timer[t] == `CC_TIMER_TOP);
    end
  end

  // A software write to a timer wins over a tick or a reload in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer[0] <= `CC_TIMER_RESET;
      timer[1] <= `CC_TIMER_RESET;
      upd <= 2'b00;
      ovf_d <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (wr_en && paddr == (t == 0 ? `CC_OFF_TIMER_A : `CC_OFF_TIMER_B)) begin
          timer[t] <= pwdata[15:0];
        end else if (ovf[t]) begin
          timer[t] <= reload[t];
        end else if (tick[t]) begin
          timer[t] <= timer[t] + 16'h0001;
        end
      end
      upd <= tick;
      ovf_d <= ovf;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reload[0] <= `CC_TIMER_RESET;
      reload[1] <= `CC_TIMER_RESET;
      run <= 2'b00;
      psc[0] <= 3'h0;
      psc[1] <= 3'h0;
      src[0] <= capcom_pkg::SRC_PRESCALED;
      src[1] <= capcom_pkg::SRC_PRESCALED;
      stagger <= 1'b0;
      mask <= '0;
      double_en <= '0;
    end else if (wr_en) begin
      case (paddr)
        `CC_OFF_RELOAD_A: reload[0] <= pwdata[15:0];
        `CC_OFF_RELOAD_B: reload[1] <= pwdata[15:0];
        `CC_OFF_CTRL: begin
          run <= {pwdata[`CC_CTRL_RUN_B], pwdata[`CC_CTRL_RUN_A]};
          psc[0] <= pwdata[`CC_CTRL_PSC_A_LO +: 3];
          psc[1] <= pwdata[`CC_CTRL_PSC_B_LO +: 3];
          src[0] <= capcom_pkg::tb_src_t'(pwdata[`CC_CTRL_SRC_A_LO +: 2]);
          src[1] <= capcom_pkg::tb_src_t'({1'b0, pwdata[`CC_CTRL_SRC_B_LO]});
          stagger <= pwdata[`CC_CTRL_STAGGER];
        end
        `CC_OFF_MASK: mask <= pwdata[CHANNELS+1:0];
        `CC_OFF_DOUBLE: double_en <= pwdata[PAIRS-1:0];
        default: ;
      endcase
    end
  end

  // Capture and compare decisions for every channel.
  always_comb begin
    logic rise;
    logic fall;
    logic match;
    rise = 1'b0;
    fall = 1'b0;
    match = 1'b0;
    for (int n = 0; n < CHANNELS; n++) begin
      rise = pin_s2[n] & ~pin_s3[n];
      fall = ~pin_s2[n] & pin_s3[n];
      case (mode[n])
        capcom_pkg::CAP_RISE: capture[n] = rise;
        capcom_pkg::CAP_FALL: capture[n] = fall;
        capcom_pkg::CAP_BOTH: capture[n] = rise | fall;
        default: capture[n] = 1'b0;
      endcase
      match = upd[tsel[n]] && (timer[tsel[n]] == value[n]);
      case (mode[n])
        capcom_pkg::CMP_M0, capcom_pkg::CMP_M1: act[n] = match & ~done[n];
        capcom_pkg::CMP_M2, capcom_pkg::CMP_M3: act[n] = match & ~done[n] & ~fired[n];
        default: act[n] = 1'b0;
      endcase
    end
  end

  // Pin outputs; the match is tested before the overflow clear, so a same-cycle match wins.
  always_comb begin
    next_pin = pin_out;
    next_oe_n = '1;
    for (int n = 0; n < CHANNELS; n++) begin
      if (n < PAIRS && double_en[n % PAIRS]) begin
        next_pin[n] = pin_out[n] ^ act[n] ^ partner_act[n];
        next_oe_n[n] = 1'b0;
      end else if (n >= PAIRS && double_en[n % PAIRS]) begin
        next_oe_n[n] = 1'b1;
      end else if (mode[n] == capcom_pkg::CMP_M1) begin
        next_pin[n] = pin_out[n] ^ act[n];
        next_oe_n[n] = 1'b0;
      end else if (mode[n] == capcom_pkg::CMP_M3) begin
        if (act[n]) begin
          next_pin[n] = 1'b1;
        end else if (ovf_d[tsel[n]]) begin
          next_pin[n] = 1'b0;
        end
        next_oe_n[n] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= next_pin;
      pin_oe_n <= next_oe_n;
    end
  end

  // Channel state; a capture overrides a software write to the same channel value.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int n = 0; n < CHANNELS; n++) begin
        value[n] <= `CC_TIMER_RESET;
        mode[n] <= capcom_pkg::CH_OFF;
      end
      tsel <= '0;
      single <= '0;
      done <= '0;
      fired <= '0;
    end else begin
      for (int n = 0; n < CHANNELS; n++) begin
        if (capture[n]) begin
          value[n] <= timer[tsel[n]];
        end else if (wr_en && value_sel && ch_idx == 4'(n)) begin
          value[n] <= pwdata[15:0];
        end
        if (wr_en && mode_sel && ch_idx == 4'(n)) begin
          mode[n] <= capcom_pkg::ch_mode_t'(pwdata[`CC_MODE_SEL_LO +: 3]);
          tsel[n] <= pwdata[`CC_MODE_TIMER_SEL];
          single[n] <= pwdata[`CC_MODE_SINGLE];
          done[n] <= 1'b0;
          fired[n] <= 1'b0;
        end else begin
          if (act[n] && single[n]) begin
            done[n] <= 1'b1;
          end
          if (act[n]) begin
            fired[n] <= 1'b1;
          end else if (ovf_d[tsel[n]]) begin
            fired[n] <= 1'b0;
          end
        end
      end
    end
  end

  // Sticky events; the set wins over a clearing read in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~reported) | events;
    end
  end

  // The request is registered, so it trails its status bit by one cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (value_sel) begin
      rd_word[15:0] = value[ch_idx];
    end else if (mode_sel) begin
      rd_word[`CC_MODE_SEL_LO +: 3] = mode[ch_idx];
      rd_word[`CC_MODE_TIMER_SEL] = tsel[ch_idx];
      rd_word[`CC_MODE_SINGLE] = single[ch_idx];
      rd_word[`CC_MODE_DONE] = done[ch_idx];
      rd_word[`CC_MODE_FIRED] = fired[ch_idx];
    end else begin
      case (paddr)
        `CC_OFF_TIMER_A: rd_word[15:0] = timer[0];
        `CC_OFF_RELOAD_A: rd_word[15:0] = reload[0];
        `CC_OFF_TIMER_B: rd_word[15:0] = timer[1];
        `CC_OFF_RELOAD_B: rd_word[15:0] = reload[1];
        `CC_OFF_CTRL: begin
          rd_word[`CC_CTRL_RUN_A] = run[0];
          rd_word[`CC_CTRL_PSC_A_LO +: 3] = psc[0];
          rd_word[`CC_CTRL_SRC_A_LO +: 2] = src[0];
          rd_word[`CC_CTRL_RUN_B] = run[1];
          rd_word[`CC_CTRL_PSC_B_LO +: 3] = psc[1];
          rd_word[`CC_CTRL_SRC_B_LO] = src[1][0];
          rd_word[`CC_CTRL_STAGGER] = stagger;
        end
        `CC_OFF_STATUS: rd_word[CHANNELS+1:0] = status;
        `CC_OFF_MASK: rd_word[CHANNELS+1:0] = mask;
        `CC_OFF_PINS: rd_word[CHANNELS-1:0] = pin_out;
        `CC_OFF_DOUBLE: rd_word[PAIRS-1:0] = double_en;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle, then drops for the next setup.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~rd_hit;
    end
  end

  // Read data is loaded in the first access cycle and held until the next read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule // capture_compare_unit

// File: logic/capcom_cfg.svh
/*
  Register offsets, field positions, reset values and widths of the capture/compare unit.
  Assumes a 32-bit APB register bus with byte addresses and one word per register.
*/
`ifndef CAPCOM_CFG_SVH
`define CAPCOM_CFG_SVH

`define CC_OFF_TIMER_A 8'h00
`define CC_OFF_RELOAD_A 8'h04
`define CC_OFF_TIMER_B 8'h08
`define CC_OFF_RELOAD_B 8'h0C
`define CC_OFF_CTRL 8'h10
`define CC_OFF_STATUS 8'h14
`define CC_OFF_MASK 8'h18
`define CC_OFF_PINS 8'h1C
`define CC_OFF_DOUBLE 8'h20
`define CC_OFF_VALUE_BASE 8'h40
`define CC_OFF_MODE_BASE 8'h80

`define CC_CTRL_RUN_A 0
`define CC_CTRL_PSC_A_LO 1
`define CC_CTRL_SRC_A_LO 4
`define CC_CTRL_RUN_B 8
`define CC_CTRL_PSC_B_LO 9
`define CC_CTRL_SRC_B_LO 12
`define CC_CTRL_STAGGER 16

`define CC_MODE_SEL_LO 0
`define CC_MODE_TIMER_SEL 3
`define CC_MODE_SINGLE 4
`define CC_MODE_DONE 5
`define CC_MODE_FIRED 6

`define CC_STAT_OVF_A 16
`define CC_STAT_OVF_B 17

`define CC_TIMER_RESET 16'h0000
`define CC_TIMER_TOP 16'hFFFF
`define CC_STAGGER_SLOTS 3'h7

`endif

// File: logic/capcom_pkg.sv
/*
  Types shared by the capture/compare unit.
  Assumes capcom_cfg.svh holds every number; this package holds only types.
*/
package capcom_pkg;

  typedef enum logic [2:0] {
    CH_OFF,
    CAP_RISE,
    CAP_FALL,
    CAP_BOTH,
    CMP_M0,
    CMP_M1,
    CMP_M2,
    CMP_M3
  } ch_mode_t;

  typedef enum logic [1:0] {
    SRC_PRESCALED,
    SRC_UPSTREAM,
    SRC_EXTERNAL,
    SRC_RESERVED
  } tb_src_t;

endpackage

// File: sim/pin_driver.sv
/*
  Far-side model of the channel pins: an external source that drives each pin level.
  Assumes the unit signals its own drive through pin_oe_n, low while it drives a pin.
*/
`timescale 1ns/10ps
module pin_driver (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] drive,
  output logic [15:0] pin_in
);
  // The unit wins where it drives, so compare outputs never read back the far side.
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & drive);
endmodule // pin_driver

// File: sim/capture_compare_unit_assertions.sv
/*
  Port-level checker of the capture/compare unit.
  Assumes it is bound to capture_compare_unit and sees only its ports.
*/
`timescale 1ns/10ps
`include "capcom_cfg.svh"
module capture_compare_unit_assertions #(
  parameter int CHANNELS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] pin_in,
  input wire logic [CHANNELS-1:0] pin_out,
  input wire logic [CHANNELS-1:0] pin_oe_n,
  input wire logic ext_count,
  input wire logic upstream_ovf,
  input wire logic irq
);
  logic wr_done;
  logic [17:0] mask_r;
  assign wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_r <= 18'h0_0000;
    end else if (wr_done && paddr == `CC_OFF_MASK) begin
      mask_r <= pwdata[17:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside a transfer");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_rdata_hold: assert property ($changed(prdata) |-> pready)
    else $error("read data moved between reads");
  a_oe_write: assert property ($changed(pin_oe_n) |->
      $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("pin drive changed without a write");
  a_irq_mask: assert property (irq |-> mask_r != 18'h0_0000 || $past(mask_r) != 18'h0_0000)
    else $error("irq with everything masked");
  a_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> !pready && !irq && pin_oe_n == '1)
    else $error("outputs not quiet after reset");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_pin: cover property ($changed(pin_out));
endmodule // capture_compare_unit_assertions

bind capture_compare_unit capture_compare_unit_assertions #(.CHANNELS(CHANNELS)) chk_u (.*);

// File: sim/tb_capture_compare_unit.sv
/*
  Self-checking bench of the capture/compare unit: APB master, pin model, read scoreboard.
  Assumes the checker is bound separately and the design answers APB as its notes say.
*/
`timescale 1ns/10ps
`include "capcom_cfg.svh"
module tb_capture_compare_unit;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext_count = 0;
  logic upstream_ovf = 0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [15:0] pin_in, pin_out, pin_oe_n, v1, v2, drive = 16'h0000;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  int chs[7] = '{4, 5, 6, 7, 15, 9, 8};
  logic [15:0] vals[7] = '{16'hFFF5, 16'hFFF5, 16'hFFF5, 16'hFFF2, 16'hFFF8, 16'hFFF5, 16'h0002};
  logic [7:0] mds[7] = '{8'h05, 8'h07, 8'h17, 8'h05, 8'h05, 8'h06, 8'h0C};
  logic [7:0] zr[7] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40, 8'h80};
  always #20 clk_sys = ~clk_sys;
  capture_compare_unit #(.CHANNELS(16)) dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .ext_count(ext_count), .upstream_ovf(upstream_ovf), .irq(irq));
  pin_driver far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drive), .pin_in(pin_in));
  task automatic cmp(input logic [32:0] got, input logic [32:0] want, input string what);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      cmp({pslverr, prdata}, e, "read");
    end
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    void'($urandom(6));
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    foreach (zr[i]) rd(zr[i], 33'h0_0000_0000);
    rd(8'h3C, 33'h1_0000_0000);
    $display("reset test done");
    wr(`CC_OFF_MASK, 32'h0003_FFFF);
    for (int m = 1; m < 4; m++) wr(8'(`CC_OFF_MODE_BASE + 4 * m), 32'(m));
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    wr(`CC_OFF_TIMER_A, {16'h0000, v1});
    drive <= 16'h000E;
    repeat (6) @(posedge clk_sys);
    wr(`CC_OFF_TIMER_A, {16'h0000, v2});
    drive <= 16'h0000;
    repeat (6) @(posedge clk_sys);
    rd(`CC_OFF_VALUE_BASE + 8'h04, {17'h0_0000, v1});
    rd(`CC_OFF_VALUE_BASE + 8'h08, {17'h0_0000, v2});
    rd(`CC_OFF_VALUE_BASE + 8'h0C, {17'h0_0000, v2});
    cmp({32'h0000_0000, irq}, 33'h0_0000_0001, "irq");
    rd(`CC_OFF_STATUS, 33'h0_0000_000E);
    repeat (3) @(posedge clk_sys);
    cmp({32'h0000_0000, irq}, 33'h0_0000_0000, "irq");
    $display("capture test done");
    wr(`CC_OFF_MASK, 32'h0000_0000);
    wr(`CC_OFF_RELOAD_A, 32'h0000_FFF0);
    wr(`CC_OFF_TIMER_A, 32'h0000_FFF0);
    wr(`CC_OFF_DOUBLE, 32'h0000_0080);
    foreach (chs[i]) begin
      wr(8'(`CC_OFF_VALUE_BASE + 4 * chs[i]), {16'h0000, vals[i]});
      wr(8'(`CC_OFF_MODE_BASE + 4 * chs[i]), {24'h00_0000, mds[i]});
    end
    wr(`CC_OFF_CTRL, 32'h0000_0021);
    // Thirty-seven external ticks: three matches at 0xFFF5 and two reloads.
    repeat (37) begin
      @(posedge clk_sys);
      ext_count <= 1;
      repeat (2) @(posedge clk_sys);
      ext_count <= 0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    rd(`CC_OFF_TIMER_A, 33'h0_0000_FFF5);
    rd(`CC_OFF_PINS, 33'h0_0000_00B0);
    cmp({29'h0000_0000, pin_out[7:4]}, 33'h0_0000_000B, "pins");
    cmp({24'h00_0000, pin_oe_n[15], pin_oe_n[7:0]}, 33'h0_0000_010F, "oe");
    cmp({32'h0000_0000, irq}, 33'h0_0000_0000, "irq");
    rd(`CC_OFF_STATUS, 33'h0_0001_82F0);
    rd(8'(`CC_OFF_MODE_BASE + 4 * 6), 33'h0_0000_0037);
    rd(8'(`CC_OFF_MODE_BASE + 4 * 9), 33'h0_0000_0046);
    $display("compare test done");
    wr(`CC_OFF_CTRL, 32'h0000_1100);
    repeat (3) begin
      @(posedge clk_sys);
      upstream_ovf <= 1;
      @(posedge clk_sys);
      upstream_ovf <= 0;
    end
    repeat (3) @(posedge clk_sys);
    rd(`CC_OFF_TIMER_B, 33'h0_0000_0003);
    rd(`CC_OFF_STATUS, 33'h0_0000_0100);
    $display("upstream test done");
    // Each run window spans 32 clocks: 8 ticks at divide-by-4, 4 ticks when staggered.
    wr(`CC_OFF_TIMER_A, 32'h0000_0000);
    wr(`CC_OFF_CTRL, 32'h0000_0005);
    repeat (28) @(posedge clk_sys);
    wr(`CC_OFF_CTRL, 32'h0000_0000);
    rd(`CC_OFF_TIMER_A, 33'h0_0000_0008);
    wr(`CC_OFF_TIMER_A, 32'h0000_0000);
    wr(`CC_OFF_CTRL, 32'h0001_0001);
    repeat (28) @(posedge clk_sys);
    wr(`CC_OFF_CTRL, 32'h0000_0000);
    rd(`CC_OFF_TIMER_A, 33'h0_0000_0004);
    $display("prescale test done");
    stop_test();
  end
endmodule // tb_capture_compare_unit
